// ### shared/standby_consts.vh
/*
 * Constants for the line transceiver power-mode controller: APB offsets,
 * field positions, reset values and timing counts.
 * Assumes a 20 MHz core clock; the idle count is overridable by parameter.
 */
`ifndef STANDBY_CONSTS_VH
`define STANDBY_CONSTS_VH

`define CLK_HZ            20000000
`define OFF_CTRL          12'h000
`define OFF_STATUS        12'h004
`define OFF_IDLE          12'h008
`define CTRL_FORCE_ACT    0
`define CTRL_PWR_UP       1
`define CTRL_ACT_CABLE    2
`define CTRL_PWR_CABLE    3
`define CTRL_RESET        4'h2
`define IDLE_TIME_S       30
`define IDLE_MIN_S        15
`define IDLE_MAX_S        60
`define IDLE_CYCLES       (`IDLE_TIME_S * `CLK_HZ)
`define WAKE_TIME_US      100
`define WAKE_CYCLES       ((`WAKE_TIME_US * `CLK_HZ) / 1000000)
`define N_DRV             3
`define N_RX              5

`endif

// ### rtl/standby_ctrl.v
/*
 * Power-mode controller for a three-driver, five-receiver line transceiver.
 * Assumes all inputs are synchronous to core_clk and that line detection
 * arrives as one bit per receiver, already thresholded.
 */
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/100ps
`include "standby_consts.vh"

// How it works
// R1 - Cable-detect output is driven in every mode, even power-down.
// R2 - Detect tied to both controls wakes fully on any live line.
// R3 - Detect tied to both controls turns drivers off when lines are dead; receivers stay on.
// R4 - Auto mode: idle past timeout tristates drivers, receivers stay on.
// R5 - Auto mode: activity keeps drivers and receivers enabled.
// R6 - Force-active from detect with live line keeps everything on.
// R7 - Force-active from detect, dead line: activity still enables drivers.
// R8 - Both from detect, dead line: drivers off, receivers on.
// R9 - Power-down low disables all outputs except the always-on receiver and cable detect; receivers stay on if both controls follow the detect.
// R10 - Idle interval lies between fifteen and sixty seconds.
// R11 - Drivers become ready about one hundred microseconds after wake.
// R12 - Force-active and power-up both high keeps everything on.
// R13 - Any driver-logic or line-receive input transition restarts idle timer and exits standby.
module standby_ctrl #(
    parameter [31:0] IDLE_CYCLES = `IDLE_CYCLES,
    parameter [31:0] WAKE_CYCLES = `WAKE_CYCLES
) (
    input  wire        core_clk,
    input  wire        rstn,
    input  wire [31:0] paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [2:0]  driver_logic_in,
    input  wire [4:0]  line_rx_in,
    input  wire [4:0]  line_live,
    output reg  [2:0]  line_driver_out,
    output reg  [2:0]  line_driver_oe_n,
    output reg  [4:0]  rx_logic_out,
    output reg  [4:0]  rx_logic_oe_n,
    output reg         always_on_rx_out,
    output reg         cable_detect_out
);
    localparam ST_ACTIVE  = 2'd0;
    localparam ST_WAKING  = 2'd1;
    localparam ST_STANDBY = 2'd2;

    reg  [3:0]  ctrl_q;
    reg  [2:0]  drv_prev_q;
    reg  [4:0]  rx_prev_q;
    reg  [31:0] idle_cnt_q;
    reg  [31:0] wake_cnt_q;
    reg  [1:0]  state_q;
    reg  [1:0]  state_d;
    wire        cable;
    wire        force_act;
    wire        pwr_up;
    wire        activity;
    wire        idle_done;
    reg         drv_en;
    reg         rx_en;
    wire        acc;
    reg  [31:0] rd_word;
    reg         rd_err;

    // Picks either the live cable detect or the manual control bit.
    // Each control input has its own select bit, so one can follow the detect while the other stays manual.
    function pick_src;
        input follow;
        input detect;
        input manual;
        begin
            pick_src = follow ? detect : manual;
        end
    endfunction

    // Packs the mode state and enables into the status word.
    function [31:0] status_word;
        input [1:0] st;
        input       drv;
        input       rx;
        input       det;
        begin
            status_word = {24'h0, st, drv, rx, det, 3'h0};
        end
    endfunction

    assign cable = |line_live;
    // R2 R3 R6 R7 R8 control sources
    // Routing the detect into a control input stands in for the board
    // wire from the detect pin to that control pin.
    assign force_act = pick_src(ctrl_q[`CTRL_ACT_CABLE], cable,
                                ctrl_q[`CTRL_FORCE_ACT]);
    assign pwr_up    = pick_src(ctrl_q[`CTRL_PWR_CABLE], cable,
                                ctrl_q[`CTRL_PWR_UP]);
    // R13 transition detect
    assign activity  = (|(drv_prev_q ^ driver_logic_in)) |
                       (|(rx_prev_q ^ line_rx_in));
    // R4 R10 idle timeout
    assign idle_done = (idle_cnt_q >= IDLE_CYCLES - 32'd1);
    assign acc = psel & penable & pready;

    // Read decode is formed in the setup cycle and registered, so the
    // answer stands in the access cycle with no wait state.
    always @* begin
        rd_word = 32'h0;
        rd_err  = 1'b0;
        case (paddr[11:0])
            `OFF_CTRL:   rd_word = {28'h0, ctrl_q};
            `OFF_STATUS: rd_word = status_word(state_q, drv_en, rx_en,
                                               cable);
            `OFF_IDLE:   rd_word = idle_cnt_q;
            default:     rd_err  = 1'b1;
        endcase
    end

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_ACTIVE: begin
                if (idle_done && !activity)
                    state_d = ST_STANDBY;
            end
            ST_STANDBY: begin
                // R13 wake on transition
                if (activity)
                    state_d = ST_WAKING;
            end
            ST_WAKING: begin
                // R11 wake latency
                if (wake_cnt_q >= WAKE_CYCLES - 32'd1)
                    state_d = ST_ACTIVE;
            end
            default: state_d = ST_ACTIVE;
        endcase
    end

    always @* begin
        drv_en = 1'b0;
        rx_en  = 1'b0;
        if (!pwr_up) begin
            // R9 R3 forced shutdown
            drv_en = 1'b0;
            rx_en  = 1'b0;
            // R8 cable shutoff mode
            // With both controls on the detect, a dead cable only parks
            // the drivers; receivers keep listening for the far end.
            if (ctrl_q[`CTRL_ACT_CABLE] && ctrl_q[`CTRL_PWR_CABLE])
                rx_en = 1'b1;
        end else if (force_act) begin
            // R12 R6 R2 forced online
            drv_en = 1'b1;
            rx_en  = 1'b1;
        end else begin
            // R4 R5 R7 auto standby
            drv_en = (state_q == ST_ACTIVE);
            rx_en  = 1'b1;
        end
    end

    always @(posedge core_clk) begin
        if (!rstn) begin
            ctrl_q           <= `CTRL_RESET;
            drv_prev_q       <= 3'h0;
            rx_prev_q        <= 5'h0;
            idle_cnt_q       <= 32'h0;
            wake_cnt_q       <= 32'h0;
            state_q          <= ST_ACTIVE;
            prdata           <= 32'h0;
            pready           <= 1'b0;
            pslverr          <= 1'b0;
            line_driver_out  <= 3'h0;
            line_driver_oe_n <= 3'h7;
            rx_logic_out     <= 5'h0;
            rx_logic_oe_n    <= 5'h1F;
            always_on_rx_out <= 1'b0;
            cable_detect_out <= 1'b0;
        end else begin
            drv_prev_q <= driver_logic_in;
            rx_prev_q  <= line_rx_in;
            state_q    <= state_d;
            // R13 idle restart
            if (activity || state_q != ST_ACTIVE)
                idle_cnt_q <= 32'h0;
            else if (!idle_done)
                idle_cnt_q <= idle_cnt_q + 32'd1;
            if (state_q == ST_WAKING)
                wake_cnt_q <= wake_cnt_q + 32'd1;
            else
                wake_cnt_q <= 32'h0;
            line_driver_out  <= driver_logic_in;
            line_driver_oe_n <= {3{~drv_en}};
            rx_logic_out     <= line_rx_in;
            rx_logic_oe_n    <= {5{~rx_en}};
            // R9 always-on receiver
            always_on_rx_out <= line_rx_in[1];
            // R1 detect always driven
            cable_detect_out <= cable;
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
            // An unmapped offset answers with an error and changes nothing.
            if (psel && !penable) begin
                prdata  <= rd_word;
                pslverr <= rd_err;
            end
            // Only the control word is writable; status and idle are read
            // only, so writes there are dropped without an error.
            if (acc && pwrite && paddr[11:0] == `OFF_CTRL)
                ctrl_q <= pwdata[3:0];
        end
    end
endmodule // standby_ctrl

// ### sim/standby_ctrl_assertions.sv
/* Port checks for standby_ctrl; assumes one clock, sync low reset. */
`timescale 1ns/100ps
module standby_ctrl_assertions (
    input wire       core_clk,
    input wire       rstn,
    input wire       psel,
    input wire       penable,
    input wire       pready,
    input wire       pslverr,
    input wire [4:0] line_rx_in,
    input wire [4:0] line_live,
    input wire [2:0] line_driver_oe_n,
    input wire [4:0] rx_logic_oe_n,
    input wire       always_on_rx_out,
    input wire       cable_detect_out,
    input wire [2:0] driver_logic_in,
    input wire [2:0] line_driver_out,
    input wire [4:0] rx_logic_out
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    chk_detect_live: assert property ($past(rstn) |->
        cable_detect_out == |$past(line_live)) else $error("bad detect");
    chk_always_on: assert property ($past(rstn) |->
        always_on_rx_out == $past(line_rx_in[1])) else $error("bad rx2");
    chk_drv_follow: assert property ($past(rstn) |->
        line_driver_out == $past(driver_logic_in)) else $error("bad drv");
    chk_rx_follow: assert property ($past(rstn) |->
        rx_logic_out == $past(line_rx_in)) else $error("bad rx data");
    chk_shut_drv: assert property (&rx_logic_oe_n |->
        &line_driver_oe_n) else $error("driver on");
    chk_drv_whole: assert property (
        line_driver_oe_n inside {3'h0, 3'h7}) else $error("split drv");
    chk_rx_whole: assert property (
        rx_logic_oe_n inside {5'h00, 5'h1F}) else $error("split rx");
    chk_apb_answer: assert property (psel && !penable |=> pready)
        else $error("late pready");
    chk_ready_pulse: assert property (pready |=> !pready) else $error("long");
    chk_err_ready: assert property (pslverr |-> pready) else $error("stray");
    cover property (!line_driver_oe_n[0] ##1 line_driver_oe_n[0]);
    cover property (&rx_logic_oe_n);
    cover property (pslverr);
endmodule // standby_ctrl_assertions

// ### sim/line_partner.sv
/* Host and cable model; assumes the bench sets act and live. */
`timescale 1ns/100ps
module line_partner (
    input  wire       core_clk,
    input  wire       act,
    input  wire       live,
    output reg  [2:0] driver_logic_in = 3'h5,
    output reg  [4:0] line_rx_in = 5'h0A,
    output wire [4:0] line_live);
    assign line_live = {5{live}};
    always @(posedge core_clk) if (act)
        {driver_logic_in, line_rx_in} <= ~{driver_logic_in, line_rx_in};
endmodule // line_partner

// ### sim/auto_standby_power_mode_control_test.sv
/* Bench for standby_ctrl; assumes short idle and wake counts. */
`timescale 1ns/100ps
module auto_standby_power_mode_control_test;
    reg core_clk = 1'h0, rstn = 1'h0, psel = 1'h0, penable = 1'h0, err;
    reg pwrite = 1'h0, act = 1'h0, live = 1'h0;
    reg [31:0] paddr = 32'h0, pwdata = 32'h0, rd;
    wire [31:0] prdata;
    wire pready, pslverr, always_on_rx_out, cable_detect_out;
    wire [2:0] driver_logic_in, line_driver_out, line_driver_oe_n;
    wire [4:0] line_rx_in, line_live, rx_logic_out, rx_logic_oe_n;
    integer num_errors = 0, tests_run = 0, cyc = 0;
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) if (++cyc > 2000) begin
        num_errors++;
        wrap_up;
    end
    line_partner i_far (.*);
    standby_ctrl #(.IDLE_CYCLES(32'h32), .WAKE_CYCLES(32'h4)) i_dut (.*);
    task chk(input [31:0] got, exp);
        begin tests_run++; if (got !== exp) begin num_errors++;
            $display("wrong value at %0t: %h not %h", $time, got, exp); end end
    endtask
    task apb(input w, input [31:0] a, d);
        begin @(posedge core_clk) {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
            @(posedge core_clk) penable <= 1'h1;
            do @(posedge core_clk); while (pready !== 1'h1);
            {rd, err} = {prdata, pslverr};
            {psel, penable} <= 2'h0; end
    endtask
    task set(input a, l); @(posedge core_clk) {act, live} <= {a, l}; endtask
    task wt(input integer n); repeat (n) @(negedge core_clk); endtask
    task t_regs; begin apb(1'h0, 32'h0, 32'h0); chk(rd, 32'h2);
        apb(1'h0, 32'h10, 32'h0); chk(err, 32'h1); $display("regs done"); end
    endtask
    task t_auto; begin set(1, 0); wt(10); chk(line_driver_oe_n, 32'h0);
        set(0, 0); wt(40); chk(line_driver_oe_n, 32'h0);
        wt(20); chk({line_driver_oe_n, rx_logic_oe_n}, 32'hE0);
        set(1, 0); set(0, 0); wt(1); chk(line_driver_oe_n, 32'h7);
        wt(12); chk(line_driver_oe_n, 32'h0); $display("auto done"); end
    endtask
    task t_shut; begin apb(1'h1, 32'h0, 32'h0); set(0, 1); wt(3);
        chk({line_driver_oe_n, rx_logic_oe_n}, 32'hFF);
        chk(always_on_rx_out, line_rx_in[1]);
        chk(cable_detect_out, 32'h1); $display("shutdown done"); end
    endtask
    task t_cable; begin apb(1'h1, 32'h0, 32'h3); set(0, 0); wt(80);
        chk(line_driver_oe_n, 32'h0); apb(1'h1, 32'h0, 32'h6);
        chk({line_driver_out, rx_logic_out}, {driver_logic_in, line_rx_in});
        set(0, 1); wt(80); chk(line_driver_oe_n, 32'h0);
        set(0, 0); wt(70); set(1, 0); wt(12); chk(line_driver_oe_n, 32'h0);
        apb(1'h1, 32'h0, 32'hC); set(0, 0); wt(5); chk(line_driver_oe_n, 32'h7);
        chk({line_driver_oe_n, rx_logic_oe_n}, 32'hE0);
        set(0, 1); wt(12); chk(line_driver_oe_n, 32'h0);
        $display("cable done"); end
    endtask
    task wrap_up; begin $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish; end
    endtask
    initial begin repeat (5) @(posedge core_clk); rstn <= 1'h1;
        t_regs; t_auto; t_shut; t_cable; wrap_up; end
endmodule // auto_standby_power_mode_control_test
bind standby_ctrl standby_ctrl_assertions i_chk (.*);
